// >>> pwm_params.svh
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH
// What this block does
// R01 - Clock select bit picks internal or external clock
// R02 - On bit off forces low; duty n gives n+1
// R03 - Period is 256 clocks, external may be 512
// R04 - Prescale bit doubles external division to 512
// R05 - Switch-on delay is code times 32 clocks
// R06 - Host writes duty, delay, then modulator enable
// R07 - Both enables in one write start in step
// R08 - Bad external clock: ignore, fault pin, flag
// R09 - Recover after flag read and clock in range
// R10 - Calibration word, then chip-select low pulse timed
// R11 - Pulse outside slot leaves period unchanged
// R12 - Gang mode: channel 1 uses channel 0 settings
// R13 - Gang status copied; bits 3 to 5 independent
// R14 - Gang mode: only channel 0 sense ratio counts
// R15 - Own open-load and short flags per own bits
// R16 - Gang overcurrent turns off and flags both
// R17 - Gang short or overtemp turns off both
// R18 - Gang retry count shared and mirrored
// R19 - Delatching channel 0 delatches both in gang
// R20 - Overtemp in on or off state: flag, pin
// R21 - Pin releases on turn-on with both cool
// R22 - Overtemp flag clears on read, cool, pin high
// R23 - Fault pin live; flags stick until read

// ---------------------------------------------------------------
// Clock and link widths
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define ADDR_W 4
`define REG_W 16

// ---------------------------------------------------------------
// Device register map
// ---------------------------------------------------------------
`define K_DUTY 3'd0
`define K_CHCFG 3'd1
`define K_OCR 3'd2
`define K_RETRY 3'd3
`define K_FAULT 3'd4
`define A_GENERAL 4'ha
`define A_CALIB 4'hb
`define A_DIAG 4'hc
`define DUTY_ON_BIT 8
`define DUTY_FULL 8'hff
`define CFG_DELAY_HI 2
`define CFG_OL_IDLE 6
`define CFG_OL_ACTIVE 7
`define CFG_OS 8
`define OCR_RATIO 5
`define OCR_INT_CLK 6
`define OCR_PRESCALE 7
`define GCR_PARALLEL 4
`define GCR_EN0 7
`define GCR_EN1 8
`define RETRY_EN 0
`define RETRY_MAX 4'hf
`define DIAG_CLK_FAIL 2
`define DELAY_SHIFT 5
`define CAL_WORD 16'h5ac3
`define INT_PERIOD_DEFAULT 16'h0010

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define EXT_PERIOD_MIN_NS 200
`define EXT_PERIOD_MAX_NS 20000
`define CAL_MIN_NS 25600
`define CAL_MAX_NS 2560000
`define EXT_MIN_CYC ((`EXT_PERIOD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_MAX_CYC (`EXT_PERIOD_MAX_NS / `CLK_PERIOD_NS)
`define CAL_MIN_CYC ((`CAL_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_MAX_CYC (`CAL_MAX_NS / `CLK_PERIOD_NS)

// ---------------------------------------------------------------
// Host APB map
// ---------------------------------------------------------------
`define H_CMD 8'h00
`define H_STATUS 8'h04
`define H_RDATA 8'h08
`define H_EXT_HALF 8'h0c
`define H_CS_PULSE 8'h10
`define CMD_READ 31
`define CMD_ADDR_LSB 16
`endif

// >>> pwm_pkg.sv
package pwm_pkg;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_DELAY = 2'b01,
    CH_RUN = 2'b11
  } ch_state_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_CS_LOW = 2'b01
  } host_state_e;
endpackage

// >>> pwm_link_if.sv
`include "pwm_params.svh"
interface pwm_link_if;
  logic reg_wr;
  logic reg_rd;
  logic [`ADDR_W-1:0] reg_addr;
  logic [`REG_W-1:0] reg_wdata;
  logic [`REG_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic ext_clock;
  logic chip_select_low;
  logic fault_status_pin_n;
  modport device (
    input reg_wr, reg_rd, reg_addr, reg_wdata, ext_clock, chip_select_low,
    output reg_rdata, reg_rvalid, fault_status_pin_n
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, ext_clock, chip_select_low,
    input reg_rdata, reg_rvalid, fault_status_pin_n
  );
endinterface

// >>> pwm_switch_device.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`include "pwm_params.svh"
module pwm_switch_device
  import pwm_pkg::*;
#(
  parameter int EXT_MIN = `EXT_MIN_CYC,
  parameter int EXT_MAX = `EXT_MAX_CYC,
  parameter int CAL_MIN = `CAL_MIN_CYC,
  parameter int CAL_MAX = `CAL_MAX_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  pwm_link_if.device link,
  input wire logic [1:0] overtemp_i,
  input wire logic [1:0] overcurrent_i,
  input wire logic [1:0] short_circuit_i,
  input wire logic [1:0] output_short_i,
  input wire logic [1:0] open_load_active_i,
  input wire logic [1:0] open_load_idle_i,
  output logic [1:0] channel_out_o,
  output logic [1:0] sense_ratio_o
);
  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (EXT_MIN < 1 || EXT_MAX <= EXT_MIN || EXT_MAX > 65535) begin : g_bad_ext
    $error("external clock window does not fit the monitor");
  end
  if (CAL_MIN < 256 || CAL_MAX <= CAL_MIN || CAL_MAX > 16777215) begin : g_bad_cal
    $error("calibration slot does not fit the timer");
  end

  // Bank used for mirrored settings
  function automatic logic src_of(input logic c, input logic p);
    return p ? 1'b0 : c;
  endfunction

  logic [1:0][8:0] duty;
  logic [1:0][8:0] chcfg;
  logic [1:0][7:0] ocr;
  logic [1:0][7:0] retry_cfg;
  logic [1:0] pwm_en;
  logic parallel;
  logic [2:0] kind;
  logic ch;
  logic [1:0] tripped, on_bit, int_sel, prescale, live;
  logic [1:0][3:0] retry_cnt;
  logic [1:0][5:0] flags;
  logic [15:0] int_period, int_cnt, gap;
  logic int_tick, ext_q, ext_rise, out_range;
  logic monitor_on, fail_active, fail_read, clk_fail_flag, diag_rd;
  logic cal_armed, cal_busy, cs_q, cs_fall, cs_rise;
  logic [23:0] cal_cnt;
  logic fsp_n, rvalid;
  logic [`REG_W-1:0] rdata, rd_word;

  assign kind = link.reg_addr[3:1];
  assign ch = link.reg_addr[0];
  assign diag_rd = link.reg_rd && link.reg_addr == `A_DIAG;
  assign ext_rise = link.ext_clock & ~ext_q;
  assign cs_fall = cs_q & ~link.chip_select_low;
  assign cs_rise = ~cs_q & link.chip_select_low;
  assign monitor_on = |(pwm_en & ~int_sel);
  assign link.reg_rdata = rdata;
  assign link.reg_rvalid = rvalid;
  assign link.fault_status_pin_n = fsp_n;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      duty <= '0;
      chcfg <= '0;
      ocr <= '0;
      retry_cfg <= '0;
      pwm_en <= '0;
      parallel <= 1'b0;
    end else if (link.reg_wr) begin
      case (kind)
        `K_DUTY: duty[ch] <= link.reg_wdata[8:0];
        `K_CHCFG: chcfg[ch] <= link.reg_wdata[8:0];
        `K_OCR: ocr[ch] <= link.reg_wdata[7:0];
        `K_RETRY: retry_cfg[ch] <= link.reg_wdata[7:0];
        default: ;
      endcase
      // One write carries both enables, so channels start together
      if (link.reg_addr == `A_GENERAL) begin
        pwm_en <= {link.reg_wdata[`GCR_EN1], link.reg_wdata[`GCR_EN0]}; // R07
        parallel <= link.reg_wdata[`GCR_PARALLEL];
      end
    end
  end

  // Internal PWM clock divider
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_cnt <= '0;
      int_tick <= 1'b0;
    end else if (int_cnt >= int_period - 16'd1) begin
      int_cnt <= '0;
      int_tick <= 1'b1;
    end else begin
      int_cnt <= int_cnt + 16'd1;
      int_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // External clock monitor
  // ---------------------------------------------------------------
  // Out of range until a good period is seen, so a dead pin fails at once
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_q <= 1'b0;
      gap <= '0;
      out_range <= 1'b1;
    end else begin
      ext_q <= link.ext_clock;
      if (ext_rise) begin
        gap <= 16'd1;
        out_range <= (gap < 16'(EXT_MIN)) || (gap >= 16'(EXT_MAX)); // R08
      end else if (gap < 16'(EXT_MAX)) begin
        gap <= gap + 16'd1;
      end else begin
        out_range <= 1'b1; // R08
      end
    end
  end

  // Failure state, released after the flag was read and the clock is back in range, or once no enabled channel uses the external clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fail_active <= 1'b0;
      fail_read <= 1'b0;
      clk_fail_flag <= 1'b0;
    end else begin
      clk_fail_flag <= (monitor_on && out_range) | (clk_fail_flag & ~diag_rd); // R08 R23
      if (!fail_active && monitor_on && out_range) begin
        fail_active <= 1'b1; // R08
      end else if (fail_active && (!monitor_on || (fail_read && !out_range))) begin
        fail_active <= 1'b0; // R09
      end
      if (!fail_active) begin
        fail_read <= 1'b0;
      end else if (diag_rd) begin
        fail_read <= 1'b1; // R09
      end
    end
  end

  // ---------------------------------------------------------------
  // Internal clock calibration
  // ---------------------------------------------------------------
  // Pulse length is one switching period, so the clock period is it over 256
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_q <= 1'b1;
      cal_armed <= 1'b0;
      cal_busy <= 1'b0;
      cal_cnt <= '0;
      int_period <= `INT_PERIOD_DEFAULT;
    end else begin
      cs_q <= link.chip_select_low;
      if (link.reg_wr && link.reg_addr == `A_CALIB && link.reg_wdata == `CAL_WORD) begin
        cal_armed <= 1'b1; // R10
      end else if (cal_armed && cs_fall) begin
        cal_armed <= 1'b0;
        cal_busy <= 1'b1;
        cal_cnt <= 24'd1;
      end else if (cal_busy && cs_rise) begin
        cal_busy <= 1'b0;
        if (cal_cnt >= 24'(CAL_MIN) && cal_cnt <= 24'(CAL_MAX)) begin // R11
          int_period <= cal_cnt[23:8]; // R10
        end
      end else if (cal_busy && cal_cnt != '1) begin
        cal_cnt <= cal_cnt + 24'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic src, oc_ev, sc_ev, ot_ev, cause_gone, on_q, delatch, retry_now;
    logic tick, half, e_retry_en, fault_rd;
    logic [8:0] e_duty;
    logic [2:0] e_delay;
    logic [5:0] set_f, clr_f;
    logic [7:0] dly, cnt;
    ch_state_e state;

    // Ganged channel 1 takes bank 0 except its diagnostic bits
    assign src = src_of(1'(g), parallel); // R12
    assign e_duty = duty[src]; // R12
    assign e_delay = chcfg[src][`CFG_DELAY_HI:0]; // R12
    assign int_sel[g] = ocr[src][`OCR_INT_CLK]; // R01
    assign prescale[g] = ocr[src][`OCR_PRESCALE]; // R04
    assign on_bit[g] = e_duty[`DUTY_ON_BIT];
    assign e_retry_en = retry_cfg[src][`RETRY_EN];
    assign oc_ev = parallel ? |overcurrent_i : overcurrent_i[g]; // R16
    assign sc_ev = parallel ? |short_circuit_i : short_circuit_i[g]; // R17
    assign ot_ev = parallel ? |overtemp_i : overtemp_i[g]; // R17 R20
    assign cause_gone = !oc_ev && !sc_ev && !(|overtemp_i); // R21
    assign delatch = on_bit[g] && !on_q; // R19
    assign retry_now = tripped[g] && e_retry_en && cause_gone && retry_cnt[g] != `RETRY_MAX;
    assign tick = int_sel[g] ? int_tick : (ext_rise && !fail_active && (!prescale[g] || half)); // R01 R04 R08
    assign fault_rd = link.reg_rd && kind == `K_FAULT && ch == 1'(g);
    assign set_f = {open_load_idle_i[g] & chcfg[g][`CFG_OL_IDLE],
                    open_load_active_i[g] & chcfg[g][`CFG_OL_ACTIVE],
                    output_short_i[g] & chcfg[g][`CFG_OS], ot_ev, sc_ev, oc_ev}; // R13 R15
    assign clr_f = fault_rd ? {3'b111, fsp_n, ~tripped[g], ~tripped[g]} : 6'b0; // R22
    assign live[g] = |set_f[5:3];

    // Trip, delatch and auto-retry
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        tripped[g] <= 1'b0;
        retry_cnt[g] <= '0;
        on_q <= 1'b0;
      end else begin
        on_q <= on_bit[g];
        if (oc_ev || sc_ev || ot_ev) begin
          tripped[g] <= 1'b1; // R16 R17 R20
        end else if (delatch && cause_gone) begin
          tripped[g] <= 1'b0; // R19 R21
          retry_cnt[g] <= '0;
        end else if (retry_now) begin
          tripped[g] <= 1'b0; // R21
          retry_cnt[g] <= retry_cnt[g] + 4'd1; // R18
        end
      end
    end

    // Sticky fault flags; a new event beats the read clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        flags[g] <= '0;
      end else begin
        flags[g] <= set_f | (flags[g] & ~clr_f); // R23 R22 R13
      end
    end

    // Modulator sequence: idle, switch-on delay, run
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        state <= CH_IDLE;
        dly <= '0;
        cnt <= '0;
        half <= 1'b0;
      end else begin
        if (state == CH_IDLE) begin
          half <= 1'b0;
        end else if (ext_rise) begin
          half <= ~half; // R04
        end
        case (state)
          CH_IDLE: begin
            cnt <= '0;
            if (pwm_en[g] && e_delay == 3'd0) begin
              state <= CH_RUN;
            end else if (pwm_en[g]) begin
              dly <= 8'(e_delay) << `DELAY_SHIFT; // R05
              state <= CH_DELAY;
            end
          end
          CH_DELAY: begin
            if (!pwm_en[g]) begin
              state <= CH_IDLE;
            end else if (tick) begin
              dly <= dly - 8'd1; // R05
              if (dly == 8'd1) begin
                state <= CH_RUN;
              end
            end
          end
          CH_RUN: begin
            if (!pwm_en[g]) begin
              state <= CH_IDLE;
            end else if (tick) begin
              cnt <= cnt + 8'd1; // R03
            end
          end
          default: state <= CH_IDLE;
        endcase
      end
    end

    // Output stage; in run a failed clock falls back to the on bit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        channel_out_o[g] <= 1'b0;
        sense_ratio_o[g] <= 1'b0;
      end else begin
        sense_ratio_o[g] <= ocr[src][`OCR_RATIO]; // R14
        if (!on_bit[g] || tripped[g]) begin
          channel_out_o[g] <= 1'b0; // R02
        end else if (state == CH_DELAY) begin
          channel_out_o[g] <= 1'b0; // R05
        end else if (state == CH_RUN && (int_sel[g] || !fail_active)) begin
          channel_out_o[g] <= (e_duty[7:0] == `DUTY_FULL) || (cnt <= e_duty[7:0]); // R02
        end else begin
          channel_out_o[g] <= 1'b1; // R08
        end
      end
    end
  end

  // Fault pin follows live causes, held trips and a failed external clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fsp_n <= 1'b1;
    end else begin
      fsp_n <= !((|tripped) || (|live) || fail_active); // R23 R20 R21 R08
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    case (kind)
      `K_DUTY: rd_word[8:0] = duty[src_of(ch, parallel)];
      `K_CHCFG: rd_word[8:0] = {chcfg[ch][8:6], chcfg[src_of(ch, parallel)][5:0]};
      `K_OCR: rd_word[7:0] = ocr[src_of(ch, parallel)]; // R14
      `K_RETRY: rd_word[7:0] = {retry_cnt[src_of(ch, parallel)], retry_cfg[src_of(ch, parallel)][3:0]}; // R18
      `K_FAULT: rd_word[5:0] = flags[ch];
      default: ;
    endcase
    if (link.reg_addr == `A_GENERAL) begin
      rd_word[`GCR_EN1] = pwm_en[1];
      rd_word[`GCR_EN0] = pwm_en[0];
      rd_word[`GCR_PARALLEL] = parallel;
    end
    if (link.reg_addr == `A_DIAG) begin
      rd_word[`DIAG_CLK_FAIL] = clk_fail_flag;
    end
  end

  // One cycle read answer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rvalid <= 1'b0;
      rdata <= '0;
    end else begin
      rvalid <= link.reg_rd;
      if (link.reg_rd) begin
        rdata <= rd_word;
      end
    end
  end
endmodule

// >>> pwm_switch_host.sv
`include "pwm_params.svh"
module pwm_switch_host
  import pwm_pkg::*;
#(
  parameter int HALF_W = 16,
  parameter int CS_W = 24
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  pwm_link_if.host link
);
  if (HALF_W < 2 || HALF_W > 32 || CS_W < 2 || CS_W > 32) begin : g_bad_w
    $error("counter widths out of range");
  end

  logic acc, setup_done, rd_pend, ext_clock, cs_low, reg_wr, reg_rd;
  logic [`ADDR_W-1:0] reg_addr;
  logic [`REG_W-1:0] reg_wdata, rdata_hold;
  logic [HALF_W-1:0] ext_half, ext_cnt;
  logic [CS_W-1:0] cs_cnt;
  host_state_e state;

  assign setup_done = psel_i && penable_i && !pready_o;
  assign acc = psel_i && penable_i && pready_o;
  assign link.reg_wr = reg_wr;
  assign link.reg_rd = reg_rd;
  assign link.reg_addr = reg_addr;
  assign link.reg_wdata = reg_wdata;
  assign link.ext_clock = ext_clock;
  assign link.chip_select_low = cs_low;

  // ---------------------------------------------------------------
  // APB slave, one wait state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else begin
      pready_o <= setup_done;
      if (setup_done) begin
        pslverr_o <= !(paddr_i == `H_CMD || paddr_i == `H_STATUS || paddr_i == `H_RDATA ||
                       paddr_i == `H_EXT_HALF || paddr_i == `H_CS_PULSE);
        case (paddr_i)
          `H_STATUS: prdata_o <= {29'b0, rd_pend, link.fault_status_pin_n, state != H_IDLE};
          `H_RDATA: prdata_o <= {16'b0, rdata_hold};
          `H_EXT_HALF: prdata_o <= 32'(ext_half);
          `H_CS_PULSE: prdata_o <= 32'(cs_cnt);
          default: prdata_o <= '0;
        endcase
      end
    end
  end

  // Command relay; software keeps order of duty, delay, enable and delatch
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= '0;
      reg_wdata <= '0;
    end else if (acc && pwrite_i && paddr_i == `H_CMD) begin
      reg_addr <= pwdata_i[`CMD_ADDR_LSB +: `ADDR_W]; // R06 R19
      reg_wdata <= pwdata_i[`REG_W-1:0];
      reg_wr <= !pwdata_i[`CMD_READ];
      reg_rd <= pwdata_i[`CMD_READ]; // R09
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  end

  // Latest read answer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_pend <= 1'b0;
      rdata_hold <= '0;
    end else begin
      if (link.reg_rvalid) begin
        rdata_hold <= link.reg_rdata;
        rd_pend <= 1'b0;
      end else if (reg_rd) begin
        rd_pend <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Shared external clock; one source keeps both channels in step
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_half <= '0;
      ext_cnt <= '0;
      ext_clock <= 1'b0;
    end else begin
      if (acc && pwrite_i && paddr_i == `H_EXT_HALF) begin
        ext_half <= pwdata_i[HALF_W-1:0];
      end
      if (ext_half == '0) begin
        ext_cnt <= '0;
        ext_clock <= 1'b0;
      end else if (ext_cnt >= ext_half - HALF_W'(1)) begin
        ext_cnt <= '0;
        ext_clock <= ~ext_clock; // R07
      end else begin
        ext_cnt <= ext_cnt + HALF_W'(1);
      end
    end
  end

  // Calibration pulse on chip select; write the calibration word first
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= H_IDLE;
      cs_low <= 1'b1;
      cs_cnt <= '0;
    end else begin
      case (state)
        H_IDLE: begin
          if (acc && pwrite_i && paddr_i == `H_CS_PULSE && pwdata_i[CS_W-1:0] != '0) begin
            cs_cnt <= pwdata_i[CS_W-1:0];
            cs_low <= 1'b0; // R10
            state <= H_CS_LOW;
          end
        end
        H_CS_LOW: begin
          if (cs_cnt == CS_W'(1)) begin
            cs_low <= 1'b1; // R10
            state <= H_IDLE;
          end
          cs_cnt <= cs_cnt - CS_W'(1);
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

// >>> pwm_link_properties.sv
`include "pwm_params.svh"
module pwm_link_properties (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic [`REG_W-1:0] reg_rdata,
  input wire logic fault_status_pin_n,
  input wire logic [1:0] overtemp_i,
  input wire logic [1:0] channel_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Link read answers, fault pin and hot channel output
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence read_taken; reg_rd; endsequence
  sequence answer_given; ##1 reg_rvalid; endsequence
  sequence hot_three; overtemp_i[0] [*3]; endsequence
  a_read_answer: assert property (read_taken |-> answer_given)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_answer_pulse: assert property (reg_rvalid && !reg_rd |=> !reg_rvalid)
    else $error("answer longer than one cycle");
  a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without answer");
  a_hot_pin: assert property (|overtemp_i |-> ##[1:3] !fault_status_pin_n)
    else $error("overtemperature not on fault pin");
  a_hot_off: assert property (hot_three |-> ##2 !channel_out_o[0])
    else $error("hot channel still on");
  a_pin_release: assert property ($rose(fault_status_pin_n) |-> $past(overtemp_i) == 2'h0)
    else $error("fault pin released while hot");
  a_pin_hot_low: assert property (!fault_status_pin_n && |overtemp_i |=> !fault_status_pin_n)
    else $error("fault pin released during fault");
endmodule

// >>> tb.sv
`include "pwm_params.svh"
module tb import pwm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [1:0] overtemp = 2'h0;
  logic [9:0] cause = 10'h000;
  logic [1:0] ratio;
  logic [1:0] channel_out_o;
  logic [64:0] expq[$];
  logic [64:0] e;
  logic [7:0] n;
  logic [7:0] m;
  int failures = 0;
  int samples_checked = 0;
  pwm_link_if link();
  always #5 clk_i = ~clk_i;
  pwm_switch_host u_pwm_switch_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .link(link.host));
  // Small monitor limits keep clock-fail detection short
  pwm_switch_device #(.EXT_MIN(2), .EXT_MAX(64), .CAL_MIN(256), .CAL_MAX(4000)) u_pwm_switch_device (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .link(link.device), .overtemp_i(overtemp),
    .overcurrent_i(cause[1:0]), .short_circuit_i(cause[3:2]), .output_short_i(cause[5:4]),
    .open_load_active_i(cause[7:6]), .open_load_idle_i(cause[9:8]), .channel_out_o(channel_out_o),
    .sense_ratio_o(ratio));
  pwm_link_properties u_pwm_link_properties (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_rd(link.reg_rd),
    .reg_rvalid(link.reg_rvalid), .reg_rdata(link.reg_rdata), .fault_status_pin_n(link.fault_status_pin_n),
    .overtemp_i(overtemp), .channel_out_o(channel_out_o));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [32:0] ex);
    expq.push_back({mk, ex});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic dev_wr(input logic [3:0] a, input logic [15:0] d);
    apb(1'b1, `H_CMD, {12'h000, a, d});
  endtask
  // The link answers a fixed number of cycles after the command lands
  task automatic dev_rd(input logic [3:0] a, input logic [31:0] mk, input logic [32:0] ex);
    apb(1'b1, `H_CMD, {12'h800, a, 16'h0000});
    repeat (4) @(posedge clk_i);
    rd(`H_RDATA, mk, ex);
  endtask
  // One window of 4096 cycles: on-time and rising edges per channel
  task automatic meas(input logic [32:0] h0, input logic [32:0] r0, input logic [32:0] h1, input logic [32:0] r1);
    logic [32:0] c[4];
    logic [1:0] p;
    c = '{default: 33'h0_0000_0000};
    p = channel_out_o;
    repeat (4096) begin
      @(posedge clk_i);
      for (int k = 0; k < 2; k++) begin
        c[2*k] += 33'(channel_out_o[k]);
        c[2*k+1] += 33'(channel_out_o[k] & ~p[k]);
      end
      p = channel_out_o;
    end
    check(c[0], h0);
    check(c[1], r0);
    check(c[2], h1);
    check(c[3], r1);
  endtask
  // Read results are compared in order as they complete
  always @(posedge clk_i) begin
    if (psel && penable && pready_o === 1'b1 && !pwrite) begin
      e = expq.pop_front();
      check({pslverr_o, prdata_o & e[64:33]}, e[32:0]);
    end
  end
  initial begin
    repeat (50000) @(posedge clk_i);
    failures++;
    test_done();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h2e30));
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    n = 8'($urandom % 255);
    m = 8'($urandom % 255);
    apb(1'b1, `H_EXT_HALF, 32'h0000_0002);
    rd(`H_EXT_HALF, 32'hffff_ffff, 33'h0_0000_0002);
    rd(8'h20, 32'hffff_ffff, 33'h1_0000_0000);
    dev_wr(4'h4, 16'h0040);
    dev_wr(4'h0, {8'h01, n});
    dev_wr(4'ha, 16'h0080);
    repeat (4096) @(posedge clk_i);
    meas((33'(n) + 33'h1) << 4, 33'h1, 33'h0, 33'h0);
    // Channel 0 on external clock, channel 1 doubled, both enabled at once
    dev_wr(4'h4, 16'h0000);
    dev_wr(4'h5, 16'h0080);
    dev_wr(4'h1, {8'h01, m});
    dev_wr(4'ha, 16'h0180);
    repeat (4096) @(posedge clk_i);
    meas((33'(n) + 33'h1) << 4, 33'h4, (33'(m) + 33'h1) << 4, 33'h2);
    apb(1'b1, `H_EXT_HALF, 32'h0000_0000);
    repeat (300) @(posedge clk_i);
    rd(`H_STATUS, 32'h0000_0002, 33'h0_0000_0000);
    dev_rd(4'hc, 32'h0000_0004, 33'h0_0000_0004);
    apb(1'b1, `H_EXT_HALF, 32'h0000_0002);
    repeat (300) @(posedge clk_i);
    rd(`H_STATUS, 32'h0000_0002, 33'h0_0000_0002);
    dev_wr(4'ha, 16'h0000);
    overtemp <= 2'h1;
    repeat (20) @(posedge clk_i);
    rd(`H_STATUS, 32'h0000_0002, 33'h0_0000_0000);
    dev_rd(4'h8, 32'h0000_0004, 33'h0_0000_0004);
    overtemp <= 2'h0;
    repeat (20) @(posedge clk_i);
    rd(`H_STATUS, 32'h0000_0002, 33'h0_0000_0000);
    dev_rd(4'h8, 32'h0000_0004, 33'h0_0000_0004);
    // Toggling the on bit is the turn-on that frees the pin
    dev_wr(4'h0, 16'h00ff);
    dev_wr(4'h0, 16'h01ff);
    repeat (20) @(posedge clk_i);
    rd(`H_STATUS, 32'h0000_0002, 33'h0_0000_0002);
    dev_rd(4'h8, 32'h0000_0004, 33'h0_0000_0004);
    dev_rd(4'h8, 32'h0000_0004, 33'h0_0000_0000);
    // Gang mode: ch1 overcurrent flags ch0, ratio follows bank 0
    dev_wr(4'ha, 16'h0010);
    dev_wr(4'h4, 16'h0020);
    cause <= 10'h002;
    repeat (5) @(posedge clk_i);
    check(33'(ratio), 33'h3);
    dev_rd(4'h8, 32'h0000_0001, 33'h0_0000_0001);
    test_done();
  end
endmodule
